// file: logic/cdcr_pkg.sv
/*
 * Shared constants and state types for the channel signal-chain configuration bank.
 * Assumes a single 250 MHz system clock and byte-wide register access from the protocol front ends.
 */
package cdcr_pkg;

	// ------------------------------------------------------------
	// Register map and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] CDCR_ADDR_U3  = 8'h42;  // Holds the data kind and averaging fields.
	localparam logic [7:0] CDCR_ADDR_U4  = 8'h43;  // channel_user_config_four.
	localparam logic [7:0] CDCR_RST_U3   = 8'h00;
	localparam logic [7:0] CDCR_RST_U4   = 8'h00;
	localparam logic [7:0] CDCR_RD_UNMAP = 8'h00;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CDCR_U3_AVG_LSB   = 0;
	localparam int CDCR_U3_KIND_LSB  = 5;
	localparam int CDCR_U4_ARM_LSB   = 0;
	localparam int CDCR_U4_PCM_BIT   = 3;
	localparam int CDCR_U4_FILT_LSB  = 4;
	localparam int CDCR_U4_INV_BIT   = 6;
	localparam int CDCR_U4_RSTOC_BIT = 7;

	// ------------------------------------------------------------
	// Field encodings
	// ------------------------------------------------------------
	localparam logic [1:0] CDCR_AVG_LPF  = 2'h0;
	localparam logic [1:0] CDCR_AVG_32   = 2'h1;
	localparam logic [1:0] CDCR_AVG_64   = 2'h2;
	localparam logic [7:0] CDCR_PER_32_US  = 8'h20;  // Typical period in microseconds.
	localparam logic [7:0] CDCR_PER_64_US  = 8'h40;
	localparam logic [7:0] CDCR_PER_128_US = 8'h80;
	localparam logic [7:0] CDCR_PER_LPF    = 8'h00;  // Period left to the low-pass filter.
	localparam logic [3:0] CDCR_MA_TAPS    = 4'h8;   // Samples in the moving average.

	localparam logic [1:0] CDCR_FILT_004_RL = 2'h0;
	localparam logic [1:0] CDCR_FILT_004    = 2'h1;
	localparam logic [1:0] CDCR_FILT_0005   = 2'h2;
	localparam logic [1:0] CDCR_FILT_BYP    = 2'h3;

	localparam logic [2:0] CDCR_ARM_HIZ = 3'h0;
	localparam logic [2:0] CDCR_ARM_PCM = 3'h1;
	localparam logic [2:0] CDCR_OC_PHASE_ONE = 3'h1;

	localparam logic [15:0] CDCR_POS_MAX = 16'h7fff;
	localparam logic [15:0] CDCR_NEG_MIN = 16'h8000;

	// Arming algorithm selection, one-hot.
	typedef enum logic [3:0] {
		CDCR_MODE_OFF   = 4'h1,
		CDCR_MODE_AVG   = 4'h2,
		CDCR_MODE_COUNT = 4'h4,
		CDCR_MODE_RAW   = 4'h8
	} cdcr_arm_mode_t;

	// Cutoff selection of the offset-cancellation filter, one-hot.
	typedef enum logic [2:0] {
		CDCR_CUT_004  = 3'h1,
		CDCR_CUT_0005 = 3'h2,
		CDCR_CUT_NONE = 3'h4
	} cdcr_oc_cut_t;

	typedef struct packed {
		logic [7:0] u3;
		logic [7:0] u4;
		logic [7:0] check;
		logic [7:0] rdata;
		logic       check_err;
		logic       dsp_rst;
		logic       dsp_busy;
		logic       arm_rst;
		logic       oc_restart;
		logic       pin_o;
		logic       pin_oe;
		logic       pull_up;
		logic       pull_down;
	} cdcr_state_t;

	typedef struct packed {
		logic [15:0] data;
		logic        valid;
	} cdcr_pol_state_t;

endpackage : cdcr_pkg

// file: logic/cdcr_pol_if.sv
/*
 * Carrier between the configuration bank and its polarity stage.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface cdcr_pol_if;
	logic        invert;
	logic [15:0] raw;
	logic        raw_valid;
	logic [15:0] out;
	logic        out_valid;

	modport cfg (output invert, output raw, output raw_valid, input out, input out_valid);
	modport pol (input invert, input raw, input raw_valid, output out, output out_valid);
endinterface : cdcr_pol_if

// file: logic/cdcr_polarity.sv
/*
 * Polarity stage: passes signed sensor samples straight or negated, one cycle of latency.
 * Assumes samples arrive as signed 16-bit words on the system clock.
 */
`timescale 1ns/1ps
module cdcr_polarity (
	input  wire logic clk_sys,
	input  wire logic arst_n,
	cdcr_pol_if.pol   pol
);
	cdcr_pkg::cdcr_pol_state_t st_r;
	cdcr_pkg::cdcr_pol_state_t st_nxt;

	// ------------------------------------------------------------
	// Negation
	// ------------------------------------------------------------
	// Self-test samples share this path, so digital self-test comes out as the two's complement and the
	// analog deltas swap sign. The most negative code saturates, since its negation does not fit.
	always_comb begin
		st_nxt       = st_r;
		st_nxt.valid = pol.raw_valid;
		if (pol.raw_valid) begin
			if (!pol.invert) begin
				st_nxt.data = pol.raw;
			end else if (pol.raw == cdcr_pkg::CDCR_NEG_MIN) begin
				st_nxt.data = cdcr_pkg::CDCR_POS_MAX;
			end else begin
				st_nxt.data = 16'(-pol.raw);
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pol.out       = st_r.data;
	assign pol.out_valid = st_r.valid;
endmodule : cdcr_polarity

// file: logic/cdcr_top.sv
/*
 * Channel signal-chain configuration bank: averaging field, user configuration byte, arming pin
 * control, offset-cancellation restart and sensor polarity.
 * Assumes the protocol front ends present byte reads and writes on the register port, and that the
 * DSP, offset-cancellation sequencer, arming algorithm and PCM modulator sit on the same clock.
 */
// Operation
// - Averaging code selects signal sampling period
// - Nonzero code: eight-sample average, no interpolation
// - Averaging field change resets DSP path
// - Restart bit forces offset cancel phase zero
// - Restart bit clears itself at phase one
// - Inversion bit negates acceleration data
// - Inversion negates digital self-test values
// - Inversion swaps analog self-test delta signs
// - Filter field selects cutoff and rate limit
// - Codes 000/001 disable or drive PCM
// - Upper codes pick mode and pin polarity
// - Arming field change resets arming function
// - PCM carries data chosen by first kind
// - Configuration byte readable and writable everywhere
// - Configuration byte covered by error detection
// - First kind field picks first data pair
`timescale 1ns/1ps
module cdcr_top (
	input  wire logic                    clk_sys,
	input  wire logic                    arst_n,
	input  wire logic [7:0]              reg_addr,
	input  wire logic                    reg_wr_en,
	input  wire logic [7:0]              reg_wdata,
	input  wire logic                    reg_rd_en,
	output logic      [7:0]              reg_rdata,
	output logic                         array_check_err,
	output logic      [1:0]              avg_period_sel,
	output logic      [7:0]              sample_period_us,
	output logic                         ma_enable,
	output logic      [3:0]              ma_taps,
	output logic                         interp_enable,
	output logic                         dsp_path_rst,
	input  wire logic                    dsp_init_done,
	output logic                         dsp_init_busy,
	input  wire logic [2:0]              oc_phase,
	output logic                         oc_restart,
	output cdcr_pkg::cdcr_oc_cut_t       oc_cutoff,
	output logic                         oc_rate_limit_en,
	output logic      [1:0]              first_data_kind_sel,
	input  wire logic [15:0]             sensor_raw,
	input  wire logic                    sensor_raw_valid,
	output logic      [15:0]             sensor_out,
	output logic                         sensor_out_valid,
	output cdcr_pkg::cdcr_arm_mode_t     arm_mode,
	output logic                         arm_rst,
	input  wire logic                    arm_active,
	input  wire logic                    pcm_bit,
	output logic                         arm_pin_o,
	output logic                         arm_pin_oe,
	output logic                         arm_pull_up_en,
	output logic                         arm_pull_down_en
);
	cdcr_pkg::cdcr_state_t st_r;
	cdcr_pkg::cdcr_state_t st_nxt;
	cdcr_pol_if            pol_if ();

	logic       wr_u3;
	logic       wr_u4;
	logic [2:0] arm_cfg_nxt;
	logic [2:0] arm_cfg_cur;
	logic       pcm_nxt;

	assign wr_u3 = reg_wr_en && (reg_addr == cdcr_pkg::CDCR_ADDR_U3);
	assign wr_u4 = reg_wr_en && (reg_addr == cdcr_pkg::CDCR_ADDR_U4);

	// ------------------------------------------------------------
	// Register file and control sequencing
	// ------------------------------------------------------------
	// Single-cycle pulses are recomputed every cycle so they never stick. The check byte is refreshed
	// from the next contents, so a mismatch can only come from a flip in the stored bits.
	always_comb begin
		st_nxt            = st_r;
		st_nxt.dsp_rst    = 1'b0;
		st_nxt.arm_rst    = 1'b0;
		st_nxt.oc_restart = 1'b0;
		if (wr_u3) begin
			st_nxt.u3 = reg_wdata;
			if (reg_wdata[cdcr_pkg::CDCR_U3_AVG_LSB +: 2] != st_r.u3[cdcr_pkg::CDCR_U3_AVG_LSB +: 2]) begin
				st_nxt.dsp_rst = 1'b1;
			end
		end
		// The sequencer reaching phase one clears the restart bit; a fresh write of one wins.
		if (oc_phase == cdcr_pkg::CDCR_OC_PHASE_ONE) begin
			st_nxt.u4[cdcr_pkg::CDCR_U4_RSTOC_BIT] = 1'b0;
		end
		if (wr_u4) begin
			st_nxt.u4 = reg_wdata;
			if (reg_wdata[cdcr_pkg::CDCR_U4_RSTOC_BIT]) begin
				st_nxt.oc_restart = 1'b1;
			end
			if (reg_wdata[cdcr_pkg::CDCR_U4_ARM_LSB +: 3] != st_r.u4[cdcr_pkg::CDCR_U4_ARM_LSB +: 3]) begin
				st_nxt.arm_rst = 1'b1;
			end
		end
		// Busy covers the whole DSP initialization so the host can hold off sensor data reads.
		// A reset arriving while busy restarts the wait, since the DSP begins its initialization again.
		if (st_nxt.dsp_rst) begin
			st_nxt.dsp_busy = 1'b1;
		end else if (dsp_init_done) begin
			st_nxt.dsp_busy = 1'b0;
		end
		st_nxt.check     = st_nxt.u3 ^ st_nxt.u4;
		st_nxt.check_err = (st_r.u3 ^ st_r.u4) != st_r.check;
		if (reg_rd_en) begin
			unique case (reg_addr)
				cdcr_pkg::CDCR_ADDR_U3: st_nxt.rdata = st_r.u3;
				cdcr_pkg::CDCR_ADDR_U4: st_nxt.rdata = st_r.u4;
				default:                st_nxt.rdata = cdcr_pkg::CDCR_RD_UNMAP;
			endcase
		end
		// Pin drive follows the configuration that takes effect with this edge.
		// Open-drain codes drive only their active level and leave the idle level to the pull current.
		arm_cfg_nxt      = st_nxt.u4[cdcr_pkg::CDCR_U4_ARM_LSB +: 3];
		pcm_nxt          = st_nxt.u4[cdcr_pkg::CDCR_U4_PCM_BIT];
		st_nxt.pull_up   = 1'b0;
		st_nxt.pull_down = 1'b0;
		if (arm_cfg_nxt == cdcr_pkg::CDCR_ARM_HIZ) begin
			st_nxt.pin_o  = 1'b0;
			st_nxt.pin_oe = 1'b0;
		end else if (arm_cfg_nxt == cdcr_pkg::CDCR_ARM_PCM) begin
			st_nxt.pin_o  = pcm_nxt & pcm_bit;
			st_nxt.pin_oe = 1'b1;
		end else if (!arm_cfg_nxt[0]) begin
			st_nxt.pin_o     = 1'b1;
			st_nxt.pin_oe    = arm_active && !st_nxt.arm_rst;
			st_nxt.pull_down = 1'b1;
		end else begin
			st_nxt.pin_o   = 1'b0;
			st_nxt.pin_oe  = arm_active && !st_nxt.arm_rst;
			st_nxt.pull_up = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_r       <= '0;
			st_r.u3    <= cdcr_pkg::CDCR_RST_U3;
			st_r.u4    <= cdcr_pkg::CDCR_RST_U4;
			st_r.check <= cdcr_pkg::CDCR_RST_U3 ^ cdcr_pkg::CDCR_RST_U4;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// Signal-chain decode
	// ------------------------------------------------------------
	// The averaging code sets period, averaging and interpolation together.
	always_comb begin
		unique case (st_r.u3[cdcr_pkg::CDCR_U3_AVG_LSB +: 2])
			cdcr_pkg::CDCR_AVG_LPF: sample_period_us = cdcr_pkg::CDCR_PER_LPF;
			cdcr_pkg::CDCR_AVG_32:  sample_period_us = cdcr_pkg::CDCR_PER_32_US;
			cdcr_pkg::CDCR_AVG_64:  sample_period_us = cdcr_pkg::CDCR_PER_64_US;
			default:                sample_period_us = cdcr_pkg::CDCR_PER_128_US;
		endcase
	end

	assign avg_period_sel = st_r.u3[cdcr_pkg::CDCR_U3_AVG_LSB +: 2];
	assign ma_enable      = avg_period_sel != cdcr_pkg::CDCR_AVG_LPF;
	assign ma_taps        = cdcr_pkg::CDCR_MA_TAPS;
	assign interp_enable  = avg_period_sel == cdcr_pkg::CDCR_AVG_LPF;

	// Offset-cancellation filter: only the lowest code keeps the rate limiter.
	always_comb begin
		unique case (st_r.u4[cdcr_pkg::CDCR_U4_FILT_LSB +: 2])
			cdcr_pkg::CDCR_FILT_004_RL: oc_cutoff = cdcr_pkg::CDCR_CUT_004;
			cdcr_pkg::CDCR_FILT_004:    oc_cutoff = cdcr_pkg::CDCR_CUT_004;
			cdcr_pkg::CDCR_FILT_0005:   oc_cutoff = cdcr_pkg::CDCR_CUT_0005;
			default:                    oc_cutoff = cdcr_pkg::CDCR_CUT_NONE;
		endcase
	end
	assign oc_rate_limit_en = st_r.u4[cdcr_pkg::CDCR_U4_FILT_LSB +: 2] == cdcr_pkg::CDCR_FILT_004_RL;

	// Arming algorithm is chosen by the upper two code bits; the lowest codes leave it idle.
	// The lowest code bit only picks the pin drive, HiZ or PCM in the lowest pair and polarity above it, so both codes of a pair share one algorithm.
	// Every pair is legal, so the case lists all four and needs no default.
	assign arm_cfg_cur = st_r.u4[cdcr_pkg::CDCR_U4_ARM_LSB +: 3];
	always_comb begin
		unique case (arm_cfg_cur[2:1])
			2'h0: arm_mode = cdcr_pkg::CDCR_MODE_OFF;
			2'h1: arm_mode = cdcr_pkg::CDCR_MODE_AVG;
			2'h2: arm_mode = cdcr_pkg::CDCR_MODE_COUNT;
			2'h3: arm_mode = cdcr_pkg::CDCR_MODE_RAW;
		endcase
	end

	assign first_data_kind_sel = st_r.u3[cdcr_pkg::CDCR_U3_KIND_LSB +: 2];

	// ------------------------------------------------------------
	// Polarity stage and outputs
	// ------------------------------------------------------------
	assign pol_if.invert    = st_r.u4[cdcr_pkg::CDCR_U4_INV_BIT];
	assign pol_if.raw       = sensor_raw;
	assign pol_if.raw_valid = sensor_raw_valid;

	cdcr_polarity u_pol (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.pol     (pol_if.pol)
	);

	assign sensor_out       = pol_if.out;
	assign sensor_out_valid = pol_if.out_valid;
	assign reg_rdata        = st_r.rdata;
	assign array_check_err  = st_r.check_err;
	assign dsp_path_rst     = st_r.dsp_rst;
	assign dsp_init_busy    = st_r.dsp_busy;
	assign oc_restart       = st_r.oc_restart;
	assign arm_rst          = st_r.arm_rst;
	assign arm_pin_o        = st_r.pin_o;
	assign arm_pin_oe       = st_r.pin_oe;
	assign arm_pull_up_en   = st_r.pull_up;
	assign arm_pull_down_en = st_r.pull_down;
endmodule : cdcr_top

// file: dv/cdcr_checker_assertions.sv
/*
 * Port-level assertions of the channel configuration bank.
 * Assumes it is bound to cdcr_top and sees only that module's ports.
 */
`timescale 1ns/1ps
module cdcr_checker (
	input wire logic                   clk_sys,
	input wire logic                   arst_n,
	input wire logic [7:0]             reg_addr,
	input wire logic                   reg_wr_en,
	input wire logic [7:0]             reg_wdata,
	input wire logic [1:0]             avg_period_sel,
	input wire logic [7:0]             sample_period_us,
	input wire logic                   ma_enable,
	input wire logic                   interp_enable,
	input wire logic                   dsp_path_rst,
	input wire logic                   dsp_init_busy,
	input wire logic                   oc_restart,
	input wire cdcr_pkg::cdcr_oc_cut_t oc_cutoff,
	input wire logic                   oc_rate_limit_en,
	input wire logic [15:0]            sensor_raw,
	input wire logic                   sensor_raw_valid,
	input wire logic [15:0]            sensor_out,
	input wire logic                   sensor_out_valid,
	input wire logic                   arm_rst,
	input wire logic                   pcm_bit,
	input wire logic                   arm_pin_o,
	input wire logic                   arm_pin_oe
);
	// ------------------------------------------------------------
	// Shadow of the user byte
	// ------------------------------------------------------------
	logic [6:0] sh_r;
	logic       w43;
	assign w43 = reg_wr_en && reg_addr == 8'h43;
	// Bit 7 is left out, since the device clears it on its own.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			sh_r <= 7'h00;
		else if (w43)
			sh_r <= reg_wdata[6:0];
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	sequence s_avg_chg; reg_wr_en && reg_addr == 8'h42 && reg_wdata[1:0] != avg_period_sel; endsequence
	sequence s_dsp_reinit; dsp_path_rst && dsp_init_busy; endsequence
	sequence s_restart_wr; w43 && reg_wdata[7]; endsequence
	property p_period; sample_period_us == (avg_period_sel == 2'h0 ? 8'h00 : 8'h10 << avg_period_sel); endproperty
	property p_ma; ma_enable == (avg_period_sel != 2'h0) && interp_enable == (avg_period_sel == 2'h0); endproperty
	property p_dsp; s_avg_chg |=> s_dsp_reinit; endproperty
	property p_rst; s_restart_wr |=> oc_restart; endproperty
	// Skipping the cycle after a write keeps this valid whether the outputs are registered or not.
	property p_filt; !$past(w43) |-> oc_rate_limit_en == (sh_r[5:4] == 2'h0) && oc_cutoff ==
		(sh_r[5:4] == 2'h3 ? cdcr_pkg::CDCR_CUT_NONE : sh_r[5:4] == 2'h2 ? cdcr_pkg::CDCR_CUT_0005
		: cdcr_pkg::CDCR_CUT_004); endproperty
	property p_inv; sensor_raw_valid |=> sensor_out_valid && sensor_out == (!$past(sh_r[6]) ? $past(sensor_raw)
		: $past(sensor_raw) == 16'h8000 ? 16'h7fff : 16'h0000 - $past(sensor_raw)); endproperty
	property p_arm; w43 && reg_wdata[2:0] != sh_r[2:0] |=> arm_rst; endproperty
	property p_pcm; sh_r[3:0] == 4'h9 && !w43 |=> arm_pin_oe && arm_pin_o == $past(pcm_bit); endproperty
	property p_hiz; sh_r[2:0] == 3'h0 && !w43 |=> !arm_pin_oe; endproperty
	a_period: assert property (p_period) else $error("sample period wrong");
	a_ma: assert property (p_ma) else $error("average or interpolation enable wrong");
	a_dsp: assert property (p_dsp) else $error("no data path reset");
	a_rst: assert property (p_rst) else $error("no offset restart pulse");
	a_filt: assert property (p_filt) else $error("offset filter selection wrong");
	a_inv: assert property (p_inv) else $error("sensor output wrong");
	a_arm: assert property (p_arm) else $error("no arming reset");
	a_pcm: assert property (p_pcm) else $error("pulse code output wrong");
	a_hiz: assert property (p_hiz) else $error("pin driven while disabled");
endmodule : cdcr_checker

// file: dv/cdcr_dsp_model.sv
/*
 * Model of the DSP and the offset-cancellation sequencer beside the bank.
 * Assumes the bank's reset pulses arrive as one-cycle pulses on clk_sys.
 */
`timescale 1ns/1ps
module cdcr_dsp_model (
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	input  wire logic       slow,
	input  wire logic       dsp_path_rst,
	input  wire logic       oc_restart,
	output logic            dsp_init_done,
	output logic      [2:0] oc_phase
);
	logic [5:0] dsp_cnt_r;
	logic [5:0] oc_cnt_r;
	// Slow answers stretch both waits, so the host side sees the busy window.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			dsp_cnt_r <= 6'h00;
			oc_cnt_r <= 6'h00;
			oc_phase <= 3'h2;
			dsp_init_done <= 1'b0;
		end else begin
			dsp_init_done <= dsp_cnt_r == 6'h01;
			if (dsp_path_rst)
				dsp_cnt_r <= slow ? 6'h28 : 6'h03;
			else if (dsp_cnt_r != 6'h00)
				dsp_cnt_r <= dsp_cnt_r - 6'h01;
			// Phase 1 lasts one cycle only, the hardest case for the clearing logic.
			if (oc_restart) begin
				oc_phase <= 3'h0;
				oc_cnt_r <= slow ? 6'h28 : 6'h02;
			end else if (oc_cnt_r != 6'h00)
				oc_cnt_r <= oc_cnt_r - 6'h01;
			else if (oc_phase < 3'h2)
				oc_phase <= oc_phase + 3'h1;
		end
	end
endmodule : cdcr_dsp_model

// file: dv/test_channel_dsp_config_regs.sv
/*
 * Self-checking bench of the configuration bank with random and corner stimulus.
 * Assumes the package, design, model and checker are compiled before it.
 */
`timescale 1ns/1ps
module test_channel_dsp_config_regs;
	logic clk_sys = 1'b0, arst_n = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0, sensor_raw_valid = 1'b0;
	logic arm_active = 1'b0, pcm_bit = 1'b0, slow = 1'b0, array_check_err, ma_enable, interp_enable;
	logic dsp_path_rst, dsp_init_done, dsp_init_busy, oc_restart, oc_rate_limit_en, sensor_out_valid, arm_rst;
	logic arm_pin_o, arm_pin_oe, arm_pull_up_en, arm_pull_down_en;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, sample_period_us;
	logic [1:0] avg_period_sel, first_data_kind_sel;
	logic [3:0] ma_taps;
	logic [2:0] oc_phase;
	logic [15:0] sensor_raw = 16'h0000, sensor_out;
	cdcr_pkg::cdcr_oc_cut_t oc_cutoff;
	cdcr_pkg::cdcr_arm_mode_t arm_mode;
	logic [31:0] seed = 32'h0d25;
	int fail_count = 0, total_checks = 0;

	cdcr_top cdcr_top_i (.clk_sys, .arst_n, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata,
		.array_check_err, .avg_period_sel, .sample_period_us, .ma_enable, .ma_taps, .interp_enable,
		.dsp_path_rst, .dsp_init_done, .dsp_init_busy, .oc_phase, .oc_restart, .oc_cutoff, .oc_rate_limit_en,
		.first_data_kind_sel, .sensor_raw, .sensor_raw_valid, .sensor_out, .sensor_out_valid, .arm_mode,
		.arm_rst, .arm_active, .pcm_bit, .arm_pin_o, .arm_pin_oe, .arm_pull_up_en, .arm_pull_down_en);
	cdcr_dsp_model cdcr_dsp_model_i (.clk_sys, .arst_n, .slow, .dsp_path_rst, .oc_restart, .dsp_init_done,
		.oc_phase);

	// Clock at 250 MHz.
	always #2 clk_sys = ~clk_sys;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		total_checks++;
		if (s !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, s);
			fail_count++;
		end
	endtask : chk
	// One strobe per access; outputs are looked at once the taking edge has landed.
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr_en <= w;
		reg_rd_en <= !w;
		@(posedge clk_sys);
		reg_wr_en <= 1'b0;
		reg_rd_en <= 1'b0;
		#1;
	endtask : acc

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		#100000;
		fail_count++;
		stop_test();
	end
	initial begin
		logic [7:0] u3, n3, u4, n4, per;
		logic [3:0] ep, mk;
		logic [2:0] c;
		u3 = 8'h00;
		u4 = 8'h00;
		repeat (10) @(posedge clk_sys);
		arst_n <= 1'b1;
		acc(1'b0, 8'h42, 8'h00);
		chk("u3 reset", 16'(cdcr_pkg::CDCR_RST_U3), 16'(reg_rdata));
		acc(1'b0, 8'h43, 8'h00);
		chk("u4 reset", 16'(cdcr_pkg::CDCR_RST_U4), 16'(reg_rdata));
		acc(1'b1, 8'h44, 8'hff);
		acc(1'b0, 8'h44, 8'h00);
		chk("unmapped", 16'(cdcr_pkg::CDCR_RD_UNMAP), 16'(reg_rdata));
		// Averaging codes in order, a repeat of the last one, then random.
		for (int i = 0; i < 8; i++) begin
			n3 = 8'(xs());
			if (i < 5)
				n3[1:0] = i == 4 ? 2'h3 : 2'(i);
			slow <= n3[7];
			acc(1'b1, 8'h42, n3);
			chk("dsp reset", 16'(n3[1:0] != u3[1:0]), 16'(dsp_path_rst));
			per = n3[1:0] == 2'h0 ? cdcr_pkg::CDCR_PER_LPF : n3[1:0] == 2'h1 ? cdcr_pkg::CDCR_PER_32_US
				: n3[1:0] == 2'h2 ? cdcr_pkg::CDCR_PER_64_US : cdcr_pkg::CDCR_PER_128_US;
			chk("period", 16'(per), 16'(sample_period_us));
			chk("avg sel", 16'(n3[1:0]), 16'(avg_period_sel));
			chk("average", {10'h0, n3[1:0] != 2'h0, n3[1:0] == 2'h0, 4'h8}, {10'h0, ma_enable, interp_enable,
				ma_taps});
			chk("first kind", 16'(n3[6:5]), 16'(first_data_kind_sel));
			for (int n = 0; n < 100 && dsp_init_busy !== 1'b0; n++) begin
				@(posedge clk_sys);
				#1;
			end
			chk("dsp busy", 16'h0000, 16'(dsp_init_busy));
			acc(1'b0, 8'h42, 8'h00);
			chk("u3 read", 16'(n3), 16'(reg_rdata));
			u3 = n3;
		end
		// Every arming code with both PCM settings, every filter code.
		for (int j = 0; j < 16; j++) begin
			c = 3'(j >> 1);
			n4 = {2'b00, 2'(j), 1'(j), c};
			acc(1'b1, 8'h43, n4);
			chk("arm reset", 16'(c != u4[2:0]), 16'(arm_rst));
			chk("rate limit", 16'(n4[5:4] == 2'h0), 16'(oc_rate_limit_en));
			chk("cutoff", n4[5:4] == 2'h3 ? 16'(cdcr_pkg::CDCR_CUT_NONE) : n4[5:4] == 2'h2 ?
				16'(cdcr_pkg::CDCR_CUT_0005) : 16'(cdcr_pkg::CDCR_CUT_004), 16'(oc_cutoff));
			chk("mode", c < 2 ? 16'(cdcr_pkg::CDCR_MODE_OFF) : c < 4 ? 16'(cdcr_pkg::CDCR_MODE_AVG) : c < 6 ?
				16'(cdcr_pkg::CDCR_MODE_COUNT) : 16'(cdcr_pkg::CDCR_MODE_RAW), 16'(arm_mode));
			@(posedge clk_sys);
			arm_active <= 1'(xs());
			pcm_bit <= 1'(xs());
			@(posedge clk_sys);
			#1;
			ep = c == 3'h0 ? 4'h0 : c == 3'h1 ? {1'b1, n4[3] & pcm_bit, 2'b00} : {arm_active, !c[0], c[0], !c[0]};
			mk = c == 3'h0 ? 4'h8 : c == 3'h1 ? 4'hc : 4'hf;
			chk("pin", 16'(ep), 16'(mk & {arm_pin_oe, arm_pin_o, arm_pull_up_en, arm_pull_down_en}));
			acc(1'b0, 8'h43, 8'h00);
			chk("u4 read", 16'(n4), 16'(reg_rdata));
			u4 = n4;
		end
		// Polarity with signed extremes and random samples.
		for (int k = 0; k < 24; k++) begin
			if (k % 12 == 0) begin
				u4[6] = k != 0;
				acc(1'b1, 8'h43, u4);
			end
			@(posedge clk_sys);
			sensor_raw <= k % 12 == 0 ? 16'h8000 : k % 12 == 1 ? 16'h7fff : k % 12 == 2 ? 16'h0000 : 16'(xs());
			sensor_raw_valid <= 1'b1;
			@(posedge clk_sys);
			sensor_raw_valid <= 1'b0;
			#1;
			chk("sensor", !u4[6] ? sensor_raw : sensor_raw == 16'h8000 ? 16'h7fff : -sensor_raw,
				sensor_out);
			chk("sensor valid", 16'h0001, 16'(sensor_out_valid));
		end
		// Restart with a slow sequencer, read while pending and after phase 1.
		slow <= 1'b1;
		acc(1'b1, 8'h43, u4 | 8'h80);
		chk("restart", 16'h0001, 16'(oc_restart));
		acc(1'b0, 8'h43, 8'h00);
		chk("restart pending", 16'h0001, 16'(reg_rdata[7]));
		for (int n = 0; n < 100 && oc_phase !== 3'h1; n++) begin
			@(posedge clk_sys);
			#1;
		end
		acc(1'b0, 8'h43, 8'h00);
		chk("restart cleared", 16'(u4), 16'(reg_rdata));
		chk("check error", 16'h0000, 16'(array_check_err));
		stop_test();
	end
endmodule : test_channel_dsp_config_regs

bind cdcr_top cdcr_checker cdcr_checker_i (.clk_sys, .arst_n, .reg_addr, .reg_wr_en, .reg_wdata, .avg_period_sel,
	.sample_period_us, .ma_enable, .interp_enable, .dsp_path_rst, .dsp_init_busy, .oc_restart, .oc_cutoff,
	.oc_rate_limit_en, .sensor_raw, .sensor_raw_valid, .sensor_out, .sensor_out_valid, .arm_rst, .pcm_bit,
	.arm_pin_o, .arm_pin_oe);
